// ===== verilog/spi_flash_front_end.sv
// Serial flash command front end: framing, opcode decode and read streaming.
`timescale 1ns/1ps

// Contract
// - Modes 0 and 3: sample input on rising clock, drive output on falling.
// - Opcode 3Bh turns the input line into a second output, two bits per clock.
// - All opcode, address and data bytes travel most significant bit first.
// - Select deassertion ends the current command frame.
// - Unsupported opcode starts nothing; input ignored until select toggles.
// - Select lost before opcode and address complete: nothing done, back to idle.
// - Three address bytes received; only the low fifteen address bits are kept.
// - Opcode 0Bh adds one dummy byte; opcode 03h streams directly after address.
// - Read keeps an address counter loaded from the start address, auto advancing.
// - After header, each falling clock shifts one read bit out (two for 3Bh), MSB first.
// - After byte 007FFFh the address wraps to zero with no extra clock.
// - Select deassertion ends a read at once and floats output, any bit position.
// - Program 02h takes three address bytes then one or more data bytes.
// - Erase opcodes 81h, 20h, 52h, D8h take three address bytes only.
// - Whole-array erase 60h, C7h, 62h carries no further bytes.
// - OTP program 9Bh with address and data; OTP read 77h adds two dummy bytes.
// - Status read 05h returns bytes; writes 01h and 31h carry one data byte.
// - Identification reads 9Fh and 15h return bytes with no address.
// - Power commands B9h, ABh and 79h carry no further bytes.
// - Dual read drives bit 7 on output line, bit 6 on second; four clocks a byte.
// - Output line stays high impedance whenever select is deasserted.
module spi_flash_front_end (
    input  wire logic                          clk,
    input  wire logic                          rst,
    input  wire logic                          csN,
    input  wire logic                          sck,
    input  wire logic                          si,
    output spi_flash_pkg::pin_out_t            pinsOut,
    output logic [spi_flash_pkg::ADDR_W-1:0]   memAddr,
    input  wire logic [7:0]                    memData,
    input  wire logic [7:0]                    respByte,
    output spi_flash_pkg::cmd_out_t            cmdOut
);

    // ******************************************************************
    // Opcode decoder
    // ******************************************************************

    // Unknown codes come back with ok low; the frame is then ignored.
    function automatic spi_flash_pkg::cmd_info_t decode(input logic [7:0] op);
        spi_flash_pkg::cmd_info_t info;
        info = '{ok: 1'b1, dual: 1'b0, addrBytes: 2'h0, dummyBytes: 2'h0,
                 src: spi_flash_pkg::SRC_NONE};
        unique case (op)
            spi_flash_pkg::OP_READ_FAST: begin
                info.addrBytes  = spi_flash_pkg::ADDR_BYTES;
                info.dummyBytes = 2'h1;
                info.src        = spi_flash_pkg::SRC_ARRAY;
            end
            spi_flash_pkg::OP_READ_SLOW: begin
                info.addrBytes = spi_flash_pkg::ADDR_BYTES;
                info.src       = spi_flash_pkg::SRC_ARRAY;
            end
            spi_flash_pkg::OP_READ_DUAL: begin
                info.addrBytes  = spi_flash_pkg::ADDR_BYTES;
                info.dummyBytes = 2'h1;
                info.dual       = 1'b1;
                info.src        = spi_flash_pkg::SRC_ARRAY;
            end
            spi_flash_pkg::OP_PAGE_ERASE, spi_flash_pkg::OP_ERASE_4K,
            spi_flash_pkg::OP_ERASE_32K_A, spi_flash_pkg::OP_ERASE_32K_B: begin
                info.addrBytes = spi_flash_pkg::ADDR_BYTES;
            end
            spi_flash_pkg::OP_PROGRAM, spi_flash_pkg::OP_OTP_PROG: begin
                info.addrBytes = spi_flash_pkg::ADDR_BYTES;
                info.src       = spi_flash_pkg::SRC_WRITE;
            end
            spi_flash_pkg::OP_OTP_READ: begin
                info.addrBytes  = spi_flash_pkg::ADDR_BYTES;
                info.dummyBytes = 2'h2;
                info.src        = spi_flash_pkg::SRC_RESP;
            end
            spi_flash_pkg::OP_STAT_READ, spi_flash_pkg::OP_ID_READ,
            spi_flash_pkg::OP_ID_OLD: begin
                info.src = spi_flash_pkg::SRC_RESP;
            end
            spi_flash_pkg::OP_STAT_WR1, spi_flash_pkg::OP_STAT_WR2,
            spi_flash_pkg::OP_SOFT_RESET: begin
                info.src = spi_flash_pkg::SRC_WRITE;
            end
            spi_flash_pkg::OP_CHIP_A, spi_flash_pkg::OP_CHIP_B, spi_flash_pkg::OP_CHIP_OLD,
            spi_flash_pkg::OP_WR_ENABLE, spi_flash_pkg::OP_WR_DISABLE,
            spi_flash_pkg::OP_POWER_DOWN, spi_flash_pkg::OP_POWER_UP,
            spi_flash_pkg::OP_ULTRA_DOWN: begin
                info.src = spi_flash_pkg::SRC_NONE;
            end
            default: begin
                info.ok = 1'b0;
            end
        endcase
        return info;
    endfunction : decode

    // ******************************************************************
    // State record
    // ******************************************************************

    typedef struct packed {
        logic [1:0]                      csMeta;
        logic [1:0]                      sckMeta;
        logic [1:0]                      siMeta;
        logic                            sckPrev;
        spi_flash_pkg::phase_t           phase;
        spi_flash_pkg::cmd_info_t        info;
        logic [2:0]                      bitCnt;
        logic [1:0]                      bytesLeft;
        logic [7:0]                      shiftIn;
        logic [spi_flash_pkg::ADDR_W-1:0] addr;
        logic [7:0]                      shiftOut;
        logic [2:0]                      outLeft;
        logic                            started;
        spi_flash_pkg::pin_out_t         pins;
        spi_flash_pkg::cmd_out_t         cmd;
    } state_t;

    state_t s_q;
    state_t s_d;

    // Outputs are fields of the registered record.
    assign pinsOut = s_q.pins;
    assign cmdOut  = s_q.cmd;
    assign memAddr = s_q.addr;

    // ******************************************************************
    // Next-state logic
    // ******************************************************************

    // Synchronised pins are bit 1 of each pair; bit 0 feeds nothing but bit 1.
    // The serial clock is only a sampled input, so sck edges must be at least
    // three system clocks apart; 40 MHz covers a host clock of a few MHz only.
    always_comb begin
        logic                     csSel;
        logic                     sckRise;
        logic                     sckFall;
        logic [7:0]               inByte;
        logic                     byteDone;
        logic                     hdrDone;
        logic [7:0]               loadByte;
        spi_flash_pkg::cmd_info_t dec;
        csSel    = 1'b0;
        sckRise  = 1'b0;
        sckFall  = 1'b0;
        inByte   = 8'h00;
        byteDone = 1'b0;
        hdrDone  = 1'b0;
        loadByte = 8'h00;
        dec      = '0;
        s_d      = s_q;

        s_d.csMeta  = {s_q.csMeta[0], csN};
        s_d.sckMeta = {s_q.sckMeta[0], sck};
        s_d.siMeta  = {s_q.siMeta[0], si};
        s_d.sckPrev = s_q.sckMeta[1];

        csSel   = ~s_q.csMeta[1];
        sckRise = s_q.sckMeta[1] & ~s_q.sckPrev;
        sckFall = ~s_q.sckMeta[1] & s_q.sckPrev;
        inByte  = {s_q.shiftIn[6:0], s_q.siMeta[1]};
        byteDone = sckRise && (s_q.bitCnt == spi_flash_pkg::LAST_BIT);

        // Handoff strobes are single-cycle pulses.
        s_d.cmd.cmdValid  = 1'b0;
        s_d.cmd.dataValid = 1'b0;
        s_d.cmd.frameDone = 1'b0;
        s_d.cmd.respNext  = 1'b0;

        if (!csSel) begin
            // Deselect ends the frame at any bit and floats both lines.
            if (s_q.phase != spi_flash_pkg::PH_IDLE) begin
                s_d.cmd.frameDone    = s_q.started;
                s_d.cmd.frameAligned = s_q.bitCnt == 3'h0;
            end
            s_d.phase       = spi_flash_pkg::PH_IDLE;
            s_d.pins.soOeN  = 1'b1;
            s_d.pins.sioOeN = 1'b1;
            s_d.started     = 1'b0;
        end else begin
            if (s_q.phase == spi_flash_pkg::PH_IDLE) begin
                // A new frame always opens with the opcode.
                s_d.phase   = spi_flash_pkg::PH_OPCODE;
                s_d.bitCnt  = 3'h0;
                s_d.outLeft = 3'h0;
            end
            if (sckRise && s_q.phase != spi_flash_pkg::PH_IDLE) begin
                s_d.shiftIn = inByte;
                s_d.bitCnt  = s_q.bitCnt + 3'h1;
            end

            // Byte-level progress on the rising edge that completes a byte.
            if (byteDone) begin
                unique case (s_q.phase)
                    spi_flash_pkg::PH_OPCODE: begin
                        dec = decode(inByte);
                        s_d.info       = dec;
                        s_d.cmd.opcode = inByte;
                        s_d.bytesLeft  = dec.addrBytes;
                        if (!dec.ok) begin
                            s_d.phase = spi_flash_pkg::PH_IGNORE;
                        end else if (dec.addrBytes != 2'h0) begin
                            s_d.phase = spi_flash_pkg::PH_ADDR;
                        end else begin
                            hdrDone = 1'b1;
                        end
                    end
                    spi_flash_pkg::PH_ADDR: begin
                        // Upper address bits fall off the top of the counter.
                        s_d.addr      = {s_q.addr[spi_flash_pkg::ADDR_W-9:0], inByte};
                        s_d.bytesLeft = s_q.bytesLeft - 2'h1;
                        if (s_q.bytesLeft == 2'h1) begin
                            if (s_q.info.dummyBytes != 2'h0) begin
                                s_d.phase     = spi_flash_pkg::PH_DUMMY;
                                s_d.bytesLeft = s_q.info.dummyBytes;
                            end else begin
                                hdrDone = 1'b1;
                            end
                        end
                    end
                    spi_flash_pkg::PH_DUMMY: begin
                        s_d.bytesLeft = s_q.bytesLeft - 2'h1;
                        if (s_q.bytesLeft == 2'h1) begin
                            hdrDone = 1'b1;
                        end
                    end
                    spi_flash_pkg::PH_WRITE: begin
                        s_d.cmd.dataValid = 1'b1;
                        s_d.cmd.dataByte  = inByte;
                    end
                    default: begin
                        s_d.phase = s_q.phase;
                    end
                endcase
            end

            // Header complete: announce the command and pick the data phase.
            if (hdrDone) begin
                s_d.started      = 1'b1;
                s_d.cmd.cmdValid = 1'b1;
                s_d.cmd.addr     = s_d.addr;
                unique case ((s_q.phase == spi_flash_pkg::PH_OPCODE) ? dec.src
                                                                      : s_q.info.src)
                    spi_flash_pkg::SRC_WRITE: s_d.phase = spi_flash_pkg::PH_WRITE;
                    spi_flash_pkg::SRC_ARRAY,
                    spi_flash_pkg::SRC_RESP:  s_d.phase = spi_flash_pkg::PH_READ;
                    default:                  s_d.phase = spi_flash_pkg::PH_IGNORE;
                endcase
            end

            // Read output on the falling edge; a new byte loads when the shifter is empty.
            if (sckFall && s_q.phase == spi_flash_pkg::PH_READ) begin
                if (s_q.outLeft == 3'h0) begin
                    if (s_q.info.src == spi_flash_pkg::SRC_ARRAY) begin
                        loadByte = memData;
                        s_d.addr = s_q.addr + 15'h0001;
                    end else begin
                        loadByte         = respByte;
                        s_d.cmd.respNext = 1'b1;
                    end
                end else begin
                    loadByte = s_q.shiftOut;
                end
                s_d.pins.so    = loadByte[7];
                s_d.pins.soOeN = 1'b0;
                if (s_q.info.dual) begin
                    s_d.pins.sio    = loadByte[6];
                    s_d.pins.sioOeN = 1'b0;
                    s_d.shiftOut    = {loadByte[5:0], 2'b00};
                    s_d.outLeft     = (s_q.outLeft == 3'h0) ? spi_flash_pkg::DUAL_RELOAD
                                                            : s_q.outLeft - 3'h1;
                end else begin
                    s_d.shiftOut = {loadByte[6:0], 1'b0};
                    s_d.outLeft  = (s_q.outLeft == 3'h0) ? spi_flash_pkg::SINGLE_RELOAD
                                                         : s_q.outLeft - 3'h1;
                end
            end
        end
    end

    // ******************************************************************
    // State register
    // ******************************************************************

    // Synchronous reset; lines float and the front end sits idle.
    always_ff @(posedge clk) begin
        if (rst) begin
            s_q             <= '0;
            s_q.csMeta      <= 2'b11;
            s_q.phase       <= spi_flash_pkg::PH_IDLE;
            s_q.pins.soOeN  <= 1'b1;
            s_q.pins.sioOeN <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

endmodule : spi_flash_front_end

// ===== common/spi_flash_pkg.sv
// Shared opcodes, phase and carrier types for the serial flash command front end.
package spi_flash_pkg;

    // ******************************************************************
    // Widths and shift counts
    // ******************************************************************
    localparam int          ADDR_W        = 15;
    localparam int          BYTE_W        = 8;
    localparam logic [2:0]  LAST_BIT      = 3'h7;
    localparam logic [1:0]  ADDR_BYTES    = 2'h3;
    localparam logic [2:0]  SINGLE_RELOAD = 3'h7;
    localparam logic [2:0]  DUAL_RELOAD   = 3'h3;

    // ******************************************************************
    // Serial clock limits the host keeps, in MHz (informational)
    // ******************************************************************
    localparam int MAX_SERIAL_CLOCK_RATE_MHZ      = 104;
    localparam int LOW_SPEED_READ_CLOCK_LIMIT_MHZ = 33;
    localparam int DUAL_READ_CLOCK_LIMIT_MHZ      = 50;

    // ******************************************************************
    // Opcodes
    // ******************************************************************
    localparam logic [7:0] OP_READ_FAST   = 8'h0b;
    localparam logic [7:0] OP_READ_SLOW   = 8'h03;
    localparam logic [7:0] OP_READ_DUAL   = 8'h3b;
    localparam logic [7:0] OP_PAGE_ERASE  = 8'h81;
    localparam logic [7:0] OP_ERASE_4K    = 8'h20;
    localparam logic [7:0] OP_ERASE_32K_A = 8'h52;
    localparam logic [7:0] OP_ERASE_32K_B = 8'hd8;
    localparam logic [7:0] OP_CHIP_A      = 8'h60;
    localparam logic [7:0] OP_CHIP_B      = 8'hc7;
    localparam logic [7:0] OP_CHIP_OLD    = 8'h62;
    localparam logic [7:0] OP_PROGRAM     = 8'h02;
    localparam logic [7:0] OP_WR_ENABLE   = 8'h06;
    localparam logic [7:0] OP_WR_DISABLE  = 8'h04;
    localparam logic [7:0] OP_OTP_PROG    = 8'h9b;
    localparam logic [7:0] OP_OTP_READ    = 8'h77;
    localparam logic [7:0] OP_STAT_READ   = 8'h05;
    localparam logic [7:0] OP_STAT_WR1    = 8'h01;
    localparam logic [7:0] OP_STAT_WR2    = 8'h31;
    localparam logic [7:0] OP_SOFT_RESET  = 8'hf0;
    localparam logic [7:0] OP_ID_READ     = 8'h9f;
    localparam logic [7:0] OP_ID_OLD      = 8'h15;
    localparam logic [7:0] OP_POWER_DOWN  = 8'hb9;
    localparam logic [7:0] OP_POWER_UP    = 8'hab;
    localparam logic [7:0] OP_ULTRA_DOWN  = 8'h79;

    // ******************************************************************
    // Types
    // ******************************************************************
    typedef enum logic [2:0] {
        PH_IDLE, PH_OPCODE, PH_ADDR, PH_DUMMY, PH_WRITE, PH_READ, PH_IGNORE
    } phase_t;

    typedef enum logic [1:0] {SRC_NONE, SRC_WRITE, SRC_ARRAY, SRC_RESP} src_t;

    typedef struct packed {
        logic       ok;
        logic       dual;
        logic [1:0] addrBytes;
        logic [1:0] dummyBytes;
        src_t       src;
    } cmd_info_t;

    typedef struct packed {
        logic so;
        logic soOeN;
        logic sio;
        logic sioOeN;
    } pin_out_t;

    typedef struct packed {
        logic              cmdValid;
        logic [7:0]        opcode;
        logic [ADDR_W-1:0] addr;
        logic              dataValid;
        logic [7:0]        dataByte;
        logic              frameDone;
        logic              frameAligned;
        logic              respNext;
    } cmd_out_t;

endpackage : spi_flash_pkg

// ===== tb/spi_flash_front_end_assertions.sv
// Concurrent checks on the pins and command outputs of the serial flash front end.
`timescale 1ns/1ps
module spi_flash_front_end_assertions (
    input  wire logic                             clk,
    input  wire logic                             rst,
    input  wire logic                             csN,
    input  wire logic                             sck,
    input  wire logic                             si,
    input  wire spi_flash_pkg::pin_out_t          pinsOut,
    input  wire logic [spi_flash_pkg::ADDR_W-1:0] memAddr,
    input  wire logic [7:0]                       memData,
    input  wire logic [7:0]                       respByte,
    input  wire spi_flash_pkg::cmd_out_t          cmdOut
);
    logic hdrSeen_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // Remembers that this frame finished its header; output must never lead it.
    always_ff @(posedge clk) begin
        if (rst || csN) hdrSeen_q <= 1'b0;
        else if (cmdOut.cmdValid) hdrSeen_q <= 1'b1;
    end

    // Steps of a frame as seen on the pins.
    sequence deselHeld; csN [*6]; endsequence
    sequence outStart; $fell(pinsOut.soOeN); endsequence
    sequence readHeader;
        cmdOut.cmdValid && (cmdOut.opcode inside {8'h03, 8'h0b, 8'h3b});
    endsequence

    float_idle_a: assert property (deselHeld |-> pinsOut.soOeN && pinsOut.sioOeN)
        else $error("Output enabled while deselected.");
    drive_after_hdr_a: assert property (outStart |-> hdrSeen_q)
        else $error("Output driven before header complete.");
    addr_step_a: assert property (!pinsOut.soOeN && $changed(memAddr) |->
        (memAddr - $past(memAddr)) == 15'h1)
        else $error("Read address did not step by one.");
    start_addr_a: assert property (readHeader |-> ##[1:2] memAddr == cmdOut.addr)
        else $error("Read counter not loaded from start address.");
    dual_only_a: assert property (!pinsOut.sioOeN |->
        !pinsOut.soOeN && cmdOut.opcode == spi_flash_pkg::OP_READ_DUAL)
        else $error("Second line driven outside dual read.");
    cmd_known_a: assert property (cmdOut.cmdValid |-> cmdOut.opcode inside {8'h0b, 8'h03,
        8'h3b, 8'h81, 8'h20, 8'h52, 8'hd8, 8'h60, 8'hc7, 8'h62, 8'h02, 8'h06, 8'h04, 8'h9b,
        8'h77, 8'h05, 8'h01, 8'h31, 8'hf0, 8'h9f, 8'h15, 8'hb9, 8'hab, 8'h79})
        else $error("Header reported for unsupported opcode.");
    data_kind_a: assert property (cmdOut.dataValid |->
        cmdOut.opcode inside {8'h02, 8'h9b, 8'h01, 8'h31, 8'hf0})
        else $error("Data byte reported for command without data.");
    cmd_selected_a: assert property (cmdOut.cmdValid |-> !csN && !$past(csN, 2))
        else $error("Header reported outside a selected frame.");
    done_deselect_a: assert property (cmdOut.frameDone |-> csN && $past(csN))
        else $error("Frame end reported while selected.");
endmodule : spi_flash_front_end_assertions

bind spi_flash_front_end spi_flash_front_end_assertions u_spi_flash_front_end_assertions (
    .clk(clk), .rst(rst), .csN(csN), .sck(sck), .si(si), .pinsOut(pinsOut),
    .memAddr(memAddr), .memData(memData), .respByte(respByte), .cmdOut(cmdOut));

// ===== tb/spi_host_model.sv
// Behavioural host master that frames commands on the serial link in mode 0.
`timescale 1ns/1ps
module spi_host_model (
    input  wire logic clk,
    output logic      csN,
    output logic      sck,
    output logic      siOut,
    input  wire logic so,
    input  wire logic sioLine
);
    // The link rests deselected with the clock low between frames.
    initial begin
        csN   = 1'b1;
        sck   = 1'b0;
        siOut = 1'b0;
    end

    // Half a link period of 100 ns, below every rate limit.
    task automatic half();
        repeat (4) @(posedge clk);
        #1;
    endtask : half

    task automatic start();
        half();
        csN = 1'b0;
        half();
    endtask : start

    // Sends the top n bits of a byte; data changes while the clock is low.
    task automatic send(input logic [7:0] b, input int n);
        for (int i = 7; i > 7 - n; i--) begin
            siOut = b[i];
            half();
            sck = 1'b1;
            half();
            sck = 1'b0;
        end
    endtask : send

    // Samples at each rising clock; the released input line keeps toggling.
    task automatic recv(input logic dual, output logic [7:0] b);
        b = 8'h00;
        for (int i = 0; i < (dual ? 4 : 8); i++) begin
            siOut = ~siOut;
            half();
            b = dual ? {b[5:0], so, sioLine} : {b[6:0], so};
            sck = 1'b1;
            half();
            sck = 1'b0;
        end
    endtask : recv

    task automatic endFrame();
        half();
        csN = 1'b1;
        repeat (3) half();
    endtask : endFrame
endmodule : spi_host_model

// ===== tb/tb.sv
// Self-checking bench for the serial flash command front end.
`timescale 1ns/1ps
module tb;
    logic                             clk;
    logic                             rst;
    logic                             csN;
    logic                             sck;
    logic                             siHost;
    logic                             siWire;
    spi_flash_pkg::pin_out_t          pinsOut;
    logic [spi_flash_pkg::ADDR_W-1:0] memAddr;
    logic [7:0]                       memData;
    logic [7:0]                       respByte;
    logic [7:0]                       respCnt;
    spi_flash_pkg::cmd_out_t          cmdOut;
    logic                             aligned;
    logic [7:0]                       dataQ[$];
    int                               nCmd;
    int                               nDone;
    int                               n_mismatch;
    int                               checks;

    spi_flash_front_end u_spi_flash_front_end (.clk(clk), .rst(rst), .csN(csN), .sck(sck),
        .si(siWire), .pinsOut(pinsOut), .memAddr(memAddr), .memData(memData),
        .respByte(respByte), .cmdOut(cmdOut));
    spi_host_model u_spi_host_model (.clk(clk), .csN(csN), .sck(sck), .siOut(siHost),
        .so(pinsOut.soOeN ? ~pinsOut.so : pinsOut.so), .sioLine(siWire));

    function automatic logic [7:0] memAt(input logic [14:0] a);
        return a[7:0] ^ a[14:7];
    endfunction : memAt

    // Array content, response supplier and the shared input wire.
    assign memData  = memAt(memAddr);
    assign respByte = 8'h5a + respCnt;
    assign siWire   = pinsOut.sioOeN ? siHost : pinsOut.sio;

    initial clk = 1'b0;
    always #12.5 clk = ~clk;

    // Collects the pulses of the command side so tasks can judge them afterwards.
    always @(posedge clk) begin
        if (rst) respCnt <= 8'h00;
        else if (cmdOut.respNext === 1'b1) respCnt <= respCnt + 8'h01;
        if (cmdOut.cmdValid === 1'b1) nCmd++;
        if (cmdOut.dataValid === 1'b1) dataQ.push_back(cmdOut.dataByte);
        if (cmdOut.frameDone === 1'b1) begin
            nDone++;
            aligned = cmdOut.frameAligned;
        end
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // Opens a frame and sends opcode, address and dummy bytes.
    task automatic hdr(input logic [7:0] op, input logic [23:0] a, input int nA, input int nD);
        nCmd  = 0;
        nDone = 0;
        dataQ.delete();
        u_spi_host_model.start();
        u_spi_host_model.send(op, 8);
        for (int i = 0; i < nA; i++) u_spi_host_model.send(a[23-8*i -: 8], 8);
        for (int i = 0; i < nD; i++) u_spi_host_model.send(8'h00, 8);
    endtask : hdr

    // Reads across the array top in every read mode, then aborts mid byte.
    task automatic t_reads();
        logic [7:0] ops [3] = '{8'h03, 8'h0b, 8'h3b};
        logic [7:0] b;
        for (int k = 0; k < 3; k++) begin
            hdr(ops[k], 24'hff7ffe, 3, (k > 0) ? 1 : 0);
            for (int j = 0; j < 3; j++) begin
                u_spi_host_model.recv(k == 2, b);
                chk("read byte", 32'(b), 32'(memAt(15'(15'h7ffe + j))));
            end
            u_spi_host_model.send(8'h00, 3);
            u_spi_host_model.endFrame();
            chk("read enables", 32'({pinsOut.soOeN, pinsOut.sioOeN}), 32'h3);
            chk("read header", 32'(nCmd), 32'h1);
        end
    endtask : t_reads

    // Status, identification and OTP reads stream supplier bytes.
    task automatic t_resp();
        logic [7:0] ops [4] = '{8'h05, 8'h9f, 8'h15, 8'h77};
        logic [7:0] b;
        logic [7:0] exp;
        for (int k = 0; k < 4; k++) begin
            exp = respByte;
            hdr(ops[k], 24'h000040, (k == 3) ? 3 : 0, (k == 3) ? 2 : 0);
            for (int j = 0; j < 2; j++) begin
                u_spi_host_model.recv(1'b0, b);
                chk("response byte", 32'(b), 32'(exp + 8'(j)));
            end
            u_spi_host_model.endFrame();
            chk("response header", 32'(nCmd), 32'h1);
        end
    endtask : t_resp

    // Commands with data bytes hand each byte on, ending on a byte boundary.
    task automatic t_writes();
        logic [7:0] ops [5] = '{8'h02, 8'h9b, 8'h01, 8'h31, 8'hf0};
        for (int k = 4; k >= 0; k--) begin
            hdr(ops[k], 24'h923456, (k < 2) ? 3 : 0, 0);
            u_spi_host_model.send(8'hd0, 8);
            if (k < 2) u_spi_host_model.send(8'h3c, 8);
            u_spi_host_model.endFrame();
            chk("data count", 32'(dataQ.size()), (k < 2) ? 32'h2 : 32'h1);
            chk("first data", 32'(dataQ[0]), 32'hd0);
            chk("aligned end", 32'({nDone == 1, aligned}), 32'h3);
            if (k < 2) chk("write addr", 32'(cmdOut.addr), 32'h3456);
        end
    endtask : t_writes

    // Erase, power and write enable/disable commands decode with or without an address.
    task automatic t_plain();
        logic [7:0] ops [12] = '{8'h81, 8'h20, 8'h52, 8'hd8, 8'h60, 8'hc7, 8'h62,
                                 8'hb9, 8'hab, 8'h79, 8'h06, 8'h04};
        for (int k = 0; k < 12; k++) begin
            hdr(ops[k], 24'h8af001, (k < 4) ? 3 : 0, 0);
            u_spi_host_model.endFrame();
            chk("plain opcode", 32'(cmdOut.opcode), 32'(ops[k]));
            chk("plain pulses", nCmd * 16 + nDone + dataQ.size() * 256, 32'h11);
            if (k < 4) chk("erase addr", 32'(cmdOut.addr), 32'h7001);
        end
    endtask : t_plain

    // Unsupported opcodes and cut headers must leave nothing behind.
    task automatic t_refuse();
        hdr(8'h00, 24'h123456, 3, 0);
        u_spi_host_model.send(8'h02, 8);
        u_spi_host_model.endFrame();
        chk("unsupported", nCmd * 16 + nDone + dataQ.size() * 256, 32'h0);
        chk("unsupported out", 32'(pinsOut.soOeN), 32'h1);
        hdr(8'h0b, 24'h123456, 2, 0);
        u_spi_host_model.endFrame();
        u_spi_host_model.start();
        u_spi_host_model.send(8'h03, 5);
        u_spi_host_model.endFrame();
        chk("short header", nCmd * 16 + nDone, 32'h0);
    endtask : t_refuse

    task automatic print_verdict();
        if (n_mismatch == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : print_verdict

    // Main sequence.
    initial begin
        n_mismatch = 0;
        checks     = 0;
        rst        = 1'b1;
        repeat (6) @(posedge clk);
        #1;
        rst = 1'b0;
        repeat (3) @(posedge clk);
        chk("idle enables", 32'({pinsOut.soOeN, pinsOut.sioOeN}), 32'h3);
        t_reads();
        t_resp();
        t_writes();
        t_plain();
        t_refuse();
        print_verdict();
    end

    // The run needs about 160 us; a hang is cut off well after that.
    initial begin
        #1_000_000;
        n_mismatch++;
        print_verdict();
    end
endmodule : tb
